// ===== in_system_flash_programmer.sv
// In-system flash programmer: registers, access checks and sequencer.
//
// Contract
// [R1] High address register gives address bits 15:8.
// [R2] Low address register gives address bits 7:0.
// [R3] Software loads data first, reads after finish.
// [R4] Go bit write starts operation, holds CPU.
// [R5] Completion releases the CPU hold.
// [R6] Go bit self-clears and reads zero.
// [R7] Trigger write needs timed-access unlock.
// [R8] Decode erase, program, read from command bits.
// [R9] Upper command bits select target region.
// [R10] Code 1011 returns maker identification byte.
// [R11] Page is 128 bytes; erase page-aligned.
// [R12] Configuration access only from loader code.
// [R13] New configuration applies only after reset.
// [R14] Main code cannot read configuration bytes.
// [R15] Loader writable from main only if enabled.
// [R16] Lock keeps loader configuration access.
// [R17] Lock does not disable programming.
// [R18] Programming needs oscillator; enable starts it.
// [R19] Software should clear enable when finished.
// [R20] Enable bit needs timed-access unlock.
// [R21] Illegal access sets fault; software clears.
// [R22] Refused operation changes nothing, completes normally.
// [R23] Trigger ignored while programming disabled.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module in_system_flash_programmer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register bus
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // CPU status
    input wire logic run_from_loader,
    input wire logic sw_reset,
    output logic cpu_hold,
    // Oscillator control
    input wire logic ext_clk_sel,
    input wire logic osc_ready,
    output logic osc_enable,
    // Flash array port
    output logic flash_req,
    output logic [1:0] flash_op,
    output logic [1:0] flash_region,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    input wire logic [7:0] flash_rdata,
    // Configuration input and output
    input wire logic [7:0] config_stored,
    output logic [7:0] config_active
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OSC = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b011
    } state_type;

    state_type state_r, state_nxt;
    logic [7:0] addr_low_r, addr_low_nxt;
    logic [7:0] addr_high_r, addr_high_nxt;
    logic [7:0] data_r, data_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic prog_en_r, prog_en_nxt;
    logic ldr_upd_r, ldr_upd_nxt;
    logic fault_r, fault_nxt;
    logic [1:0] ta_r, ta_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic hold_r, hold_nxt;
    logic req_r, req_nxt;
    logic [1:0] fop_r, fop_nxt;
    logic is_read_r, is_read_nxt;
    logic timer_start;
    logic [19:0] timer_cycles;
    logic timer_done;
    logic [7:0] cfg_r;
    logic cfg_loaded_r;
    logic [15:0] target;
    logic ta_open;
    logic go_write;
    logic [2:0] op_kind;
    logic refused;

    // Validity of a command: returns 1 erase, 2 program, 3 read, 4 id.
    function automatic logic [2:0] decode_op(input logic [7:0] c);
        logic oe;
        logic ce;
        oe = c[flash_prog_pkg::CMD_OE];
        ce = c[flash_prog_pkg::CMD_CE];
        decode_op = 3'h0;
        if (!ce) begin // [R8]
            if (c[3:0] == flash_prog_pkg::OP_ERASE && oe)
                decode_op = 3'h1;
            else if (c[3:0] == flash_prog_pkg::OP_PROGRAM && oe)
                decode_op = 3'h2;
            else if (c[3:0] == flash_prog_pkg::OP_READ && !oe)
                decode_op = 3'h3;
            else if (c[3:0] == flash_prog_pkg::OP_MAKER_ID && !oe) // [R10]
                decode_op = 3'h4;
        end
    endfunction : decode_op

    // Region size limit for oversize checks.
    function automatic logic [15:0] region_size(input logic [1:0] r);
        case (r)
            flash_prog_pkg::REG_MAIN: region_size = flash_prog_pkg::MAIN_SIZE;
            flash_prog_pkg::REG_LOADER:
                region_size = flash_prog_pkg::LOADER_SIZE;
            flash_prog_pkg::REG_CONFIG:
                region_size = flash_prog_pkg::CONFIG_SIZE;
            default: region_size = 16'h0000;
        endcase
    endfunction : region_size

    assign target = {addr_high_r, addr_low_r}; // [R1] [R2]
    assign ta_open = (ta_r == 2'h2);
    assign go_write = reg_wr && reg_addr == flash_prog_pkg::ADDR_TRIGGER
        && ta_open && reg_wdata[flash_prog_pkg::GO_BIT]; // [R4] [R7]
    assign op_kind = decode_op(cmd_r);

    // Lock state is deliberately not consulted here: it must not block
    // programming, and loader code keeps full configuration access.
    always_comb begin // [R16] [R17]
        refused = 1'b0;
        if (op_kind == 3'h0) begin
            refused = 1'b1;
        end else if (op_kind != 3'h4) begin // [R9]
            if (target >= region_size(cmd_r[7:6]))
                refused = 1'b1; // [R21]
            if (op_kind != 3'h3) begin
                if (cmd_r[7:6] == flash_prog_pkg::REG_MAIN
                    && !run_from_loader)
                    refused = 1'b1; // [R21]
                if (cmd_r[7:6] == flash_prog_pkg::REG_LOADER
                    && run_from_loader)
                    refused = 1'b1; // [R21]
                if (cmd_r[7:6] == flash_prog_pkg::REG_LOADER
                    && !run_from_loader && !ldr_upd_r)
                    refused = 1'b1; // [R15]
            end
            if (cmd_r[7:6] == flash_prog_pkg::REG_CONFIG && !run_from_loader)
                refused = 1'b1; // [R12] [R14]
            if (op_kind == 3'h1
                && target[flash_prog_pkg::PAGE_BITS-1:0] != 7'h00)
                refused = 1'b1; // [R11]
        end
    end

    always_comb begin
        timer_cycles = 20'(flash_prog_pkg::READ_CYCLES);
        if (op_kind == 3'h1)
            timer_cycles = 20'(flash_prog_pkg::ERASE_CYCLES);
        else if (op_kind == 3'h2)
            timer_cycles = 20'(flash_prog_pkg::PROG_CYCLES);
    end

    always_comb begin
        state_nxt = state_r;
        addr_low_nxt = addr_low_r;
        addr_high_nxt = addr_high_r;
        data_nxt = data_r;
        cmd_nxt = cmd_r;
        prog_en_nxt = prog_en_r;
        ldr_upd_nxt = ldr_upd_r;
        fault_nxt = fault_r;
        ta_nxt = ta_r;
        rdata_nxt = 8'h00;
        hold_nxt = hold_r;
        req_nxt = 1'b0;
        fop_nxt = fop_r;
        is_read_nxt = is_read_r;
        timer_start = 1'b0;
        if (reg_wr) begin
            // Idle bus cycles keep the unlock; any other write relocks.
            ta_nxt = 2'h0;
            if (reg_addr == flash_prog_pkg::ADDR_TIMED_ACCESS) begin
                if (reg_wdata == flash_prog_pkg::TA_KEY1)
                    ta_nxt = 2'h1;
                else if (reg_wdata == flash_prog_pkg::TA_KEY2 && ta_r == 2'h1)
                    ta_nxt = 2'h2;
            end
            case (reg_addr)
                flash_prog_pkg::ADDR_ADDR_LOW: addr_low_nxt = reg_wdata;
                flash_prog_pkg::ADDR_ADDR_HIGH: addr_high_nxt = reg_wdata;
                flash_prog_pkg::ADDR_FLASH_DATA: data_nxt = reg_wdata;
                flash_prog_pkg::ADDR_COMMAND: cmd_nxt = reg_wdata;
                flash_prog_pkg::ADDR_CHIP_CTRL: begin
                    if (ta_open) begin // [R20]
                        prog_en_nxt = reg_wdata[flash_prog_pkg::CC_PROG_EN];
                    end
                    ldr_upd_nxt = reg_wdata[flash_prog_pkg::CC_LDR_UPD];
                    if (!reg_wdata[flash_prog_pkg::CC_FAULT])
                        fault_nxt = 1'b0; // [R21]
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                flash_prog_pkg::ADDR_ADDR_LOW: rdata_nxt = addr_low_r;
                flash_prog_pkg::ADDR_ADDR_HIGH: rdata_nxt = addr_high_r;
                flash_prog_pkg::ADDR_FLASH_DATA: rdata_nxt = data_r; // [R3]
                flash_prog_pkg::ADDR_COMMAND: rdata_nxt = cmd_r;
                flash_prog_pkg::ADDR_CHIP_CTRL:
                    rdata_nxt = {1'b0, fault_r, ldr_upd_r, 3'h0,
                                 config_active[flash_prog_pkg::CC_BOOT_SEL],
                                 prog_en_r};
                default: rdata_nxt = 8'h00; // [R6]
            endcase
        end
        case (state_r)
            ST_IDLE: begin
                if (go_write && prog_en_r) begin // [R23]
                    hold_nxt = 1'b1; // [R4]
                    state_nxt = ST_OSC;
                end
            end
            ST_OSC: begin
                if (osc_ready) begin // [R18]
                    if (refused) begin
                        if (op_kind != 3'h0)
                            fault_nxt = 1'b1; // [R21]
                        state_nxt = ST_DONE; // [R22]
                    end else if (op_kind == 3'h4) begin
                        data_nxt = flash_prog_pkg::MAKER_ID; // [R10]
                        state_nxt = ST_DONE;
                    end else begin
                        req_nxt = 1'b1;
                        is_read_nxt = (op_kind == 3'h3);
                        fop_nxt = (op_kind == 3'h1) ? 2'b10 :
                                  (op_kind == 3'h2) ? 2'b01 : 2'b00;
                        timer_start = 1'b1;
                        state_nxt = ST_BUSY;
                    end
                end
            end
            ST_BUSY: begin
                if (timer_done) begin
                    if (is_read_r)
                        data_nxt = flash_rdata;
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                hold_nxt = 1'b0; // [R5]
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            addr_low_r <= flash_prog_pkg::RST_ADDR_LOW;
            addr_high_r <= flash_prog_pkg::RST_ADDR_HIGH;
            data_r <= flash_prog_pkg::RST_FLASH_DATA;
            cmd_r <= flash_prog_pkg::RST_COMMAND;
            prog_en_r <= 1'b0;
            ldr_upd_r <= 1'b0;
            fault_r <= 1'b0;
            ta_r <= 2'h0;
            rdata_r <= 8'h00;
            hold_r <= 1'b0;
            req_r <= 1'b0;
            fop_r <= 2'b00;
            is_read_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_low_r <= addr_low_nxt;
            addr_high_r <= addr_high_nxt;
            data_r <= data_nxt;
            cmd_r <= cmd_nxt;
            prog_en_r <= prog_en_nxt;
            ldr_upd_r <= ldr_upd_nxt;
            fault_r <= fault_nxt;
            ta_r <= ta_nxt;
            rdata_r <= rdata_nxt;
            hold_r <= hold_nxt;
            req_r <= req_nxt;
            fop_r <= fop_nxt;
            is_read_r <= is_read_nxt;
        end
    end

    // Stored configuration is sampled once after reset release. A software
    // reset reloads everything except the boot-select bit.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= 8'h00;
            cfg_loaded_r <= 1'b0;
        end else if (!cfg_loaded_r) begin
            cfg_r <= config_stored; // [R13]
            cfg_loaded_r <= 1'b1;
        end else if (sw_reset) begin
            cfg_r <= {config_stored[7:2], cfg_r[flash_prog_pkg::CC_BOOT_SEL],
                      config_stored[0]}; // [R13]
        end
    end

    flash_op_timer u_timer (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .start(timer_start),
        .cycles(timer_cycles),
        .done(timer_done)
    );

    assign reg_rdata = rdata_r;
    assign cpu_hold = hold_r;
    // The oscillator stays on with an internal clock; an external clock
    // lets it stop once programming is disabled, saving power.
    assign osc_enable = prog_en_r || !ext_clk_sel || hold_r; // [R18]
    assign flash_req = req_r;
    assign flash_op = fop_r;
    assign flash_region = cmd_r[7:6];
    assign flash_addr = target;
    assign flash_wdata = data_r;
    assign config_active = cfg_r;

    go_reads_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reg_rd && reg_addr == flash_prog_pkg::ADDR_TRIGGER
        |=> reg_rdata == 8'h00) else $error("trigger read nonzero"); // [R6]
    no_unlock_go_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == ST_IDLE && reg_wr && reg_addr == flash_prog_pkg::ADDR_TRIGGER
        && !ta_open |=> !cpu_hold) else $error("locked go taken"); // [R7]
    disabled_go_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == ST_IDLE && !prog_en_r |=> !cpu_hold)
        else $error("go while disabled"); // [R23]
    go_holds_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == ST_IDLE && go_write && prog_en_r |=> cpu_hold)
        else $error("go did not hold"); // [R4]
    done_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == ST_DONE |=> !cpu_hold && state_r == ST_IDLE)
        else $error("no release"); // [R5]
    refused_quiet_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == ST_OSC && osc_ready && refused |=> !flash_req ##1 !cpu_hold)
        else $error("refused op ran"); // [R22]
    cfg_read_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == ST_OSC && cmd_r[7:6] == flash_prog_pkg::REG_CONFIG
        && !run_from_loader && osc_ready |=> !flash_req)
        else $error("config read from main"); // [R14]
    fault_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == ST_OSC && osc_ready && refused && op_kind != 3'h0
        |=> fault_r) else $error("fault not set"); // [R21]
    id_value_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == ST_OSC && osc_ready && !refused && op_kind == 3'h4
        |=> data_r == flash_prog_pkg::MAKER_ID) else $error("bad id"); // [R10]
    addr_map_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reg_wr && reg_addr == flash_prog_pkg::ADDR_ADDR_HIGH
        |=> flash_addr[15:8] == $past(reg_wdata))
        else $error("address mismatch"); // [R1]
endmodule : in_system_flash_programmer

// ===== flash_prog_pkg.sv
// Constants shared by the in-system flash programmer and its flash port.
package flash_prog_pkg;
    // Register addresses on the special function register bus.
    localparam logic [7:0] ADDR_TRIGGER = 8'ha4;
    localparam logic [7:0] ADDR_ADDR_LOW = 8'ha6;
    localparam logic [7:0] ADDR_ADDR_HIGH = 8'ha7;
    localparam logic [7:0] ADDR_FLASH_DATA = 8'hae;
    localparam logic [7:0] ADDR_COMMAND = 8'haf;
    localparam logic [7:0] ADDR_CHIP_CTRL = 8'h9f;
    localparam logic [7:0] ADDR_TIMED_ACCESS = 8'hc7;
    // Reset values.
    localparam logic [7:0] RST_ADDR_LOW = 8'h00;
    localparam logic [7:0] RST_ADDR_HIGH = 8'h00;
    localparam logic [7:0] RST_FLASH_DATA = 8'h00;
    localparam logic [7:0] RST_COMMAND = 8'h30;
    // Field positions.
    localparam int GO_BIT = 0;
    localparam int CC_PROG_EN = 0;
    localparam int CC_BOOT_SEL = 1;
    localparam int CC_LDR_UPD = 5;
    localparam int CC_FAULT = 6;
    localparam int CMD_OE = 5;
    localparam int CMD_CE = 4;
    // Timed-access unlock bytes.
    localparam logic [7:0] TA_KEY1 = 8'haa;
    localparam logic [7:0] TA_KEY2 = 8'h55;
    // Operation codes.
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_PROGRAM = 4'h1;
    localparam logic [3:0] OP_ERASE = 4'h2;
    localparam logic [3:0] OP_MAKER_ID = 4'hb;
    // Region selects from the two upper command bits.
    localparam logic [1:0] REG_MAIN = 2'h0;
    localparam logic [1:0] REG_LOADER = 2'h1;
    localparam logic [1:0] REG_CONFIG = 2'h3;
    // Arbitrary maker identification value.
    localparam logic [7:0] MAKER_ID = 8'h5a;
    // Geometry.
    localparam int PAGE_BITS = 7;
    localparam logic [15:0] MAIN_SIZE = 16'h4000;
    localparam logic [15:0] LOADER_SIZE = 16'h1000;
    localparam logic [15:0] CONFIG_SIZE = 16'h0004;
    // Flash timing.
    localparam int CLK_MHZ = 200;
    localparam int PROG_TIME_US = 20;
    localparam int ERASE_TIME_US = 5000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int READ_CYCLES = 2;
    localparam int OSC_START_CYCLES = 4;
    localparam int CNT_W = 20;
    // Flash operation encoding on the array port.
    typedef enum logic [1:0] {
        FOP_READ = 2'b00,
        FOP_PROG = 2'b01,
        FOP_ERASE = 2'b10
    } flash_op_type;
endpackage : flash_prog_pkg

// ===== flash_op_timer.sv
// Cycle counter that times one flash array operation.
`timescale 1ns/1ps
module flash_op_timer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Control
    input wire logic start,
    input wire logic [19:0] cycles,
    // Status
    output logic done
);
    logic [19:0] cnt_r;
    logic [19:0] cnt_nxt;
    logic run_r;
    logic run_nxt;
    logic done_nxt;
    logic done_r;

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        done_nxt = 1'b0;
        if (start) begin
            cnt_nxt = cycles;
            run_nxt = 1'b1;
        end else if (run_r) begin
            if (cnt_r <= 20'h00001) begin
                run_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - 20'h00001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 20'h00000;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule : flash_op_timer

// ===== flash_array_model.sv
// Behavioural flash array and oscillator facing the programmer.
`timescale 1ns/1ps
module flash_array_model (
    // Clock
    input wire logic sys_clk,
    // Flash array port
    input wire logic flash_req,
    input wire logic [1:0] flash_op,
    input wire logic [1:0] flash_region,
    input wire logic [15:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    output logic [7:0] flash_rdata,
    // Oscillator
    input wire logic osc_enable,
    output logic osc_ready
);
    logic [7:0] mem [0:3][0:255];
    logic [7:0] last = 8'h00;
    logic [3:0] age = 4'hf;
    logic [2:0] warm = 3'h0;
    logic [1:0] last_op = 2'h3;
    logic [1:0] last_reg = 2'h2;
    int req_cnt = 0;
    initial begin
        for (int r = 0; r < 4; r++) begin
            for (int a = 0; a < 256; a++) begin
                mem[r][a] = 8'(r * 37 + a);
            end
        end
    end
    // The array aliases on the low address byte to stay small.
    always @(posedge sys_clk) begin
        warm <= !osc_enable ? 3'h0 : (warm == 3'h7 ? warm : warm + 3'h1);
        if (flash_req) begin
            req_cnt <= req_cnt + 1;
            last_op <= flash_op;
            last_reg <= flash_region;
            age <= 4'h0;
            last <= mem[flash_region][flash_addr[7:0]];
            if (flash_op == 2'b01) begin
                mem[flash_region][flash_addr[7:0]] <= flash_wdata;
            end
        end else if (age != 4'hf) begin
            age <= age + 4'h1;
        end
    end
    assign osc_ready = (warm == 3'h7);
    // Read data stands a few cycles, then flips so a late sample shows up.
    assign flash_rdata = (age < 4'h8) ? last : ~last;
endmodule : flash_array_model

// ===== in_system_flash_programmer_bench.sv
// Self-checking bench for the in-system flash programmer.
`timescale 1ns/1ps
module in_system_flash_programmer_bench;
    typedef struct {string what; logic [7:0] mask; logic [7:0] exp;} note_type;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run_from_loader = 1'b0;
    logic sw_reset = 1'b0;
    logic ext_clk_sel = 1'b1;
    logic [7:0] config_stored = 8'h3c;
    logic [7:0] reg_rdata, flash_wdata, flash_rdata, config_active;
    logic [15:0] flash_addr;
    logic [1:0] flash_op, flash_region;
    logic cpu_hold, osc_enable, osc_ready, flash_req, rd_pend = 1'b0;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int r0;
    logic [15:0] a;
    logic [7:0] d;
    note_type q[$];
    note_type n;

    in_system_flash_programmer uut (.sys_clk(sys_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .run_from_loader(run_from_loader), .sw_reset(sw_reset),
        .cpu_hold(cpu_hold), .ext_clk_sel(ext_clk_sel),
        .osc_ready(osc_ready), .osc_enable(osc_enable),
        .flash_req(flash_req), .flash_op(flash_op),
        .flash_region(flash_region), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
        .config_stored(config_stored), .config_active(config_active));
    flash_array_model m (.sys_clk(sys_clk), .flash_req(flash_req),
        .flash_op(flash_op), .flash_region(flash_region),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_rdata(flash_rdata), .osc_enable(osc_enable),
        .osc_ready(osc_ready));

    always #2.5 sys_clk = ~sys_clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= dt;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // The expected value is noted when the read is issued.
    task automatic rd(input logic [7:0] ad, input logic [7:0] mask,
                      input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        q.push_back('{what, mask, exp});
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic unlock();
        wr(flash_prog_pkg::ADDR_TIMED_ACCESS, flash_prog_pkg::TA_KEY1);
        wr(flash_prog_pkg::ADDR_TIMED_ACCESS, flash_prog_pkg::TA_KEY2);
    endtask : unlock

    task automatic en(input logic [7:0] dt);
        unlock();
        wr(flash_prog_pkg::ADDR_CHIP_CTRL, dt);
    endtask : en

    task automatic set_op(input logic [7:0] cmd, input logic [15:0] ad);
        wr(flash_prog_pkg::ADDR_ADDR_HIGH, ad[15:8]);
        wr(flash_prog_pkg::ADDR_ADDR_LOW, ad[7:0]);
        wr(flash_prog_pkg::ADDR_COMMAND, cmd);
    endtask : set_op

    // Fires the trigger and follows the hold until it drops.
    task automatic run_op(input logic hold, input int dreq);
        int k;
        r0 = m.req_cnt;
        unlock();
        wr(flash_prog_pkg::ADDR_TRIGGER, 8'h01);
        @(negedge sys_clk);
        check("cpu_hold", {7'h0, cpu_hold}, {7'h0, hold});
        k = 0;
        while (cpu_hold !== 1'b0 && k < 9000) begin
            @(negedge sys_clk);
            k++;
        end
        check("hold released", {7'h0, cpu_hold}, 8'h00);
        check("requests", 8'(m.req_cnt - r0), 8'(dreq));
    endtask : run_op

    always @(posedge sys_clk) begin
        rd_pend <= reg_rd;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            close_out();
        end
    end

    always @(negedge sys_clk) begin
        if (rd_pend) begin
            n = q.pop_front();
            check(n.what, reg_rdata & n.mask, n.exp);
        end
    end

    initial begin
        void'($urandom(1));
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check("config_active", config_active, 8'h3c);
        rd(8'ha6, 8'hff, flash_prog_pkg::RST_ADDR_LOW, "addr low");
        rd(8'ha7, 8'hff, flash_prog_pkg::RST_ADDR_HIGH, "addr high");
        rd(8'hae, 8'hff, flash_prog_pkg::RST_FLASH_DATA, "data");
        rd(8'haf, 8'hff, flash_prog_pkg::RST_COMMAND, "command");
        rd(8'ha4, 8'hff, 8'h00, "trigger");
        rd(8'h00, 8'hff, 8'h00, "unmapped");
        $display("test reset values done");
        a = 16'($urandom);
        set_op(8'h0b, a);
        rd(8'ha7, 8'hff, a[15:8], "addr high");
        rd(8'ha6, 8'hff, a[7:0], "addr low");
        check("flash_addr high", flash_addr[15:8], a[15:8]);
        check("flash_addr low", flash_addr[7:0], a[7:0]);
        $display("test address done");
        check("osc off", {7'h0, osc_enable}, 8'h00);
        run_op(1'b0, 0);
        wr(flash_prog_pkg::ADDR_CHIP_CTRL, 8'h01);
        @(negedge sys_clk);
        check("locked enable", {7'h0, osc_enable}, 8'h00);
        en(8'h01);
        @(negedge sys_clk);
        check("osc on", {7'h0, osc_enable}, 8'h01);
        wr(flash_prog_pkg::ADDR_TRIGGER, 8'h01);
        @(negedge sys_clk);
        check("bare trigger", {7'h0, cpu_hold}, 8'h00);
        $display("test protection done");
        run_op(1'b1, 0);
        rd(8'hae, 8'hff, flash_prog_pkg::MAKER_ID, "maker id");
        rd(8'ha4, 8'hff, 8'h00, "trigger");
        $display("test maker id done");
        a = 16'($urandom) & 16'h3fff;
        set_op(8'h00, a);
        run_op(1'b1, 1);
        check("read op", {6'h0, m.last_op}, 8'h00);
        check("read region", {6'h0, m.last_reg}, 8'h00);
        rd(8'hae, 8'hff, m.mem[0][a[7:0]], "read data");
        $display("test main read done");
        d = 8'($urandom);
        set_op(8'h61, 16'h0010);
        wr(8'hae, d);
        run_op(1'b1, 0);
        rd(8'h9f, 8'h40, 8'h40, "fault");
        en(8'h21);
        rd(8'h9f, 8'h40, 8'h00, "fault cleared");
        run_op(1'b1, 1);
        check("prog op", {6'h0, m.last_op}, 8'h01);
        check("prog region", {6'h0, m.last_reg}, 8'h01);
        check("programmed", m.mem[1][8'h10], d);
        $display("test loader program done");
        set_op(8'hc0, 16'h0001);
        run_op(1'b1, 0);
        rd(8'h9f, 8'h40, 8'h40, "fault");
        run_from_loader <= 1'b1;
        en(8'h01);
        run_op(1'b1, 1);
        check("config region", {6'h0, m.last_reg}, 8'h03);
        rd(8'hae, 8'hff, m.mem[3][1], "config data");
        set_op(8'h22, 16'h0081);
        run_op(1'b1, 0);
        $display("test config and erase done");
        en(8'h00);
        @(negedge sys_clk);
        check("osc stopped", {7'h0, osc_enable}, 8'h00);
        @(posedge sys_clk);
        ext_clk_sel <= 1'b0;
        @(negedge sys_clk);
        check("osc internal", {7'h0, osc_enable}, 8'h01);
        $display("test enable off done");
        config_stored <= 8'ha5;
        repeat (4) @(posedge sys_clk);
        check("config held", config_active, 8'h3c);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("config reloaded", config_active, 8'ha5);
        config_stored <= 8'h3e;
        sw_reset <= 1'b1;
        @(posedge sys_clk);
        sw_reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("soft reset", config_active, 8'h3c);
        $display("test config reload done");
        repeat (3) @(posedge sys_clk);
        close_out();
    end
endmodule : in_system_flash_programmer_bench
